// ==== core/lma_top.sv ====
// Purpose: host port for flash attributes, custom glyph memory and control word
// Assumes: host pins asynchronous; ref_clk is the refresh clock
// Notes:   a write is taken once per select-low period, on its falling strobe
`timescale 1ns/1ps
// Notes on behaviour
// - one flash bit per character position
// - attribute select picks space; ignore upper address
// - low three address bits pick flash bit
// - data bit zero sets or clears flash
// - flash enable bit flashes marked characters
// - flash period is clock divided by 28672
// - flash disabled means attribute memory ignored
// - upper lines 00 reach glyph index register
// - glyph index takes data bits three to zero
// - upper lines 01 reach glyph rows, row select
// - control word eight bits, written whole
// - control word fields act independently
// - brightness code 000 full, 111 blank
// - row write stores five dots, bits four-zero
// - select and strobe low make an access
module lma_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // host pins
  input  wire logic        select_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        attribute_space_select,
  input  wire logic [4:0]  addr,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe,
  // display side
  output logic      [7:0]  char_visible,
  output logic             led_enable,
  output logic      [3:0]  custom_glyph_index,
  output logic      [7:0]  display_control_word
);
  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  lma_pkg::lma_bus_s bus_raw;
  lma_pkg::lma_bus_s bus;
  lma_pkg::lma_bus_s bus_idle;

  assign bus_raw = '{select_n: select_n, read_n: read_n, write_n: write_n,
                     attr_space: attribute_space_select, addr: addr, wdata: data_in};
  assign bus_idle = '{select_n: 1'b1, read_n: 1'b1, write_n: 1'b1,
                      attr_space: 1'b0, addr: 5'h00, wdata: 8'h00};

  lma_sync #(.W($bits(lma_pkg::lma_bus_s))) u_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .d_in    (bus_raw),
    .rst_val (bus_idle),
    .q_out   (bus)
  );

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic       wr_active;
  logic       rd_active;
  logic       wr_done_reg;
  logic       wr_done_next;
  logic       wr_fire;
  logic [1:0] space;
  logic [2:0] low_addr;

  assign wr_active = !bus.select_n && !bus.write_n && bus.read_n;
  assign rd_active = !bus.select_n && !bus.read_n && bus.write_n;
  // one write per select-low period; the host must lift select in between
  assign wr_fire   = wr_active && !wr_done_reg;
  assign space     = bus.addr[4:3];
  assign low_addr  = bus.addr[2:0];

  always_comb begin
    wr_done_next = wr_done_reg;
    if (bus.select_n) begin
      wr_done_next = 1'b0;
    end else if (wr_active) begin
      wr_done_next = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] flash_reg;
  logic [7:0] flash_next;
  logic [3:0] glyph_idx_reg;
  logic [3:0] glyph_idx_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [lma_pkg::GLYPH_DOTS_W-1:0] glyph_mem [lma_pkg::GLYPH_COUNT][lma_pkg::GLYPH_ROWS];
  logic       row_wr;
  logic [4:0] row_rdata;

  always_comb begin
    flash_next     = flash_reg;
    glyph_idx_next = glyph_idx_reg;
    ctrl_next      = ctrl_reg;
    row_wr         = 1'b0;
    if (wr_fire) begin
      if (!bus.attr_space) begin
        flash_next[low_addr] = bus.wdata[0];
      end else begin
        unique case (space)
          lma_pkg::SPACE_GLYPH_INDEX: glyph_idx_next = bus.wdata[3:0];
          lma_pkg::SPACE_GLYPH_ROW:   row_wr = (low_addr != 3'h7);
          lma_pkg::SPACE_CONTROL:     ctrl_next = bus.wdata;
          lma_pkg::SPACE_OTHER:       ctrl_next = ctrl_reg;
        endcase
      end
    end
  end

  // glyph rows have no reset: contents survive like the ram they model
  always_ff @(posedge ref_clk) begin
    if (row_wr) begin
      glyph_mem[glyph_idx_reg][low_addr] <= bus.wdata[4:0];
    end
  end

  assign row_rdata = (low_addr == 3'h7) ? 5'h00 : glyph_mem[glyph_idx_reg][low_addr];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;
  logic       oe_next;
  logic       oe_reg;

  always_comb begin
    rdata_next = 8'h00;
    oe_next    = rd_active;
    if (!bus.attr_space) begin
      rdata_next = {7'h00, flash_reg[low_addr]};
    end else begin
      unique case (space)
        lma_pkg::SPACE_GLYPH_INDEX: rdata_next = {4'h0, glyph_idx_reg};
        lma_pkg::SPACE_GLYPH_ROW:   rdata_next = {3'h0, row_rdata};
        lma_pkg::SPACE_CONTROL:     rdata_next = ctrl_reg;
        lma_pkg::SPACE_OTHER:       rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // flash timebase and brightness modulation
  // ----------------------------------------------------------------
  logic [14:0] flash_cnt_reg;
  logic [14:0] flash_cnt_next;
  logic        flash_phase_reg;
  logic        flash_phase_next;
  logic [2:0]  pwm_reg;
  logic [2:0]  pwm_next;
  logic [7:0]  vis_next;
  logic [7:0]  vis_reg;
  logic        led_next;
  logic        led_reg;
  logic [2:0]  bright;

  assign bright = ctrl_reg[lma_pkg::CTRL_BRIGHT_MSB:lma_pkg::CTRL_BRIGHT_LSB];

  always_comb begin
    flash_cnt_next   = flash_cnt_reg + 15'h0001;
    flash_phase_next = flash_phase_reg;
    // toggle every half period gives a full period of 28672 clocks
    if (flash_cnt_reg == 15'(lma_pkg::FLASH_HALF - 1)) begin
      flash_cnt_next   = 15'h0000;
      flash_phase_next = !flash_phase_reg;
    end
    pwm_next = pwm_reg + 3'h1;
    // on for (7 - code) of 8 slots, code 000 forced on in all 8: 000 full, 111 dark
    led_next = (pwm_reg < (3'h7 - bright)) || (bright == 3'h0);
    if (ctrl_reg[lma_pkg::CTRL_FLASH_BIT]) begin
      vis_next = ~(flash_reg & {8{flash_phase_reg}});
    end else begin
      vis_next = 8'hFF;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_done_reg     <= 1'b0;
      flash_reg       <= lma_pkg::FLASH_RESET;
      glyph_idx_reg   <= lma_pkg::GLYPH_IDX_RESET;
      ctrl_reg        <= lma_pkg::CTRL_RESET;
      rdata_reg       <= 8'h00;
      oe_reg          <= 1'b0;
      flash_cnt_reg   <= 15'h0000;
      flash_phase_reg <= 1'b0;
      pwm_reg         <= 3'h0;
      vis_reg         <= 8'hFF;
      led_reg         <= 1'b0;
    end else begin
      wr_done_reg     <= wr_done_next;
      flash_reg       <= flash_next;
      glyph_idx_reg   <= glyph_idx_next;
      ctrl_reg        <= ctrl_next;
      rdata_reg       <= rdata_next;
      oe_reg          <= oe_next;
      flash_cnt_reg   <= flash_cnt_next;
      flash_phase_reg <= flash_phase_next;
      pwm_reg         <= pwm_next;
      vis_reg         <= vis_next;
      led_reg         <= led_next;
    end
  end

  assign data_out             = rdata_reg;
  assign data_oe              = oe_reg;
  assign char_visible         = vis_reg;
  assign led_enable           = led_reg;
  assign custom_glyph_index   = glyph_idx_reg;
  assign display_control_word = ctrl_reg;
endmodule

// ==== core/lma_pkg.sv ====
// Purpose: shared constants and types for the led matrix attribute access block
// Assumes: 100 MHz ref_clk standing in for the refresh clock
// Notes:   all decode values and counts live here
package lma_pkg;
  // ----------------------------------------------------------------
  // decode of the upper address lines while attribute space is selected
  // ----------------------------------------------------------------
  localparam logic [1:0] SPACE_GLYPH_INDEX = 2'h0;
  localparam logic [1:0] SPACE_GLYPH_ROW   = 2'h1;
  localparam logic [1:0] SPACE_CONTROL     = 2'h2;
  localparam logic [1:0] SPACE_OTHER       = 2'h3;
  // ----------------------------------------------------------------
  // control word fields, reset values and sizes
  // ----------------------------------------------------------------
  localparam int          CTRL_BRIGHT_LSB  = 0;
  localparam int          CTRL_BRIGHT_MSB  = 2;
  localparam int          CTRL_FLASH_BIT   = 3;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  FLASH_RESET      = 8'h00;
  localparam logic [3:0]  GLYPH_IDX_RESET  = 4'h0;
  localparam int          GLYPH_IDX_W      = 4;
  localparam int          GLYPH_DOTS_W     = 5;
  localparam int          GLYPH_ROWS       = 7;
  localparam int          GLYPH_COUNT      = 16;
  localparam int          CHAR_COUNT       = 8;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          FLASH_DIVIDE     = 28672;
  localparam int          FLASH_HALF       = FLASH_DIVIDE / 2;
  localparam int          PWM_STEPS        = 8;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       select_n;
    logic       read_n;
    logic       write_n;
    logic       attr_space;
    logic [4:0] addr;
    logic [7:0] wdata;
  } lma_bus_s;
endpackage

// ==== core/lma_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: input is asynchronous to ref_clk
// Notes:   output only changes once stages two and three agree
`timescale 1ns/1ps
module lma_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // data
  input  wire logic [W-1:0] d_in,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  // stages and output reset to zero, not to the idle level; from the first clock on the output stays on rst_val
  // until all three stages hold real pin samples; otherwise zeros would leak out
  logic [1:0]   fill_reg;
  logic [1:0]   fill_next;

  always_comb begin
    fill_next = fill_reg;
    if (fill_reg != 2'h3) begin
      fill_next = fill_reg + 2'h1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        q_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : q_reg[i];
        if (fill_reg != 2'h3) begin
          q_next[i] = rst_val[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      q_reg    <= '0;
      fill_reg <= 2'h0;
    end else begin
      s1_reg   <= d_in;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      q_reg    <= q_next;
      fill_reg <= fill_next;
    end
  end

  assign q_out = q_reg;
endmodule

// ==== sim/lma_chk_assertions.sv ====
// Purpose: port assertions for lma_top
// Assumes: host pins held at least six cycles per phase
// Notes:   windows allow for the four-edge pin filter
`timescale 1ns/1ps
module lma_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       resetn,
  // watched pins
  input wire logic       select_n,
  input wire logic       read_n,
  input wire logic       write_n,
  input wire logic       attribute_space_select,
  input wire logic [4:0] addr,
  input wire logic       data_oe,
  input wire logic [7:0] char_visible,
  input wire logic       led_enable,
  input wire logic [3:0] custom_glyph_index,
  input wire logic [7:0] display_control_word
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_oe_from_read: assert property (
    $rose(data_oe) |-> $past(!read_n && !select_n, 4)) else $error("oe without read");
  chk_idle_no_oe: assert property (
    select_n [*7] |-> !data_oe) else $error("oe while idle");
  chk_flash_off_lit: assert property (
    (!display_control_word[3]) [*3] |-> char_visible == 8'hFF) else $error("flash off");
  chk_blank_code: assert property (
    (display_control_word[2:0] == 3'h7) [*4] |-> !led_enable) else $error("not blank");
  chk_full_code: assert property (
    (display_control_word[2:0] == 3'h0) [*4] |-> led_enable) else $error("not full");
  chk_index_write: assert property (
    $changed(custom_glyph_index) |-> $past(!write_n && !select_n && attribute_space_select
    && addr[4:3] == 2'h0, 3)) else $error("index changed without write");
  chk_ctrl_write: assert property (
    $changed(display_control_word) |-> $past(!write_n && !select_n && attribute_space_select
    && addr[4:3] == 2'h2, 3)) else $error("control changed without write");
  chk_flash_gate: assert property (
    char_visible != 8'hFF |-> $past(display_control_word[3])) else $error("blank w/o enable");
endmodule
bind lma_top lma_chk u_chk (.ref_clk, .resetn, .select_n, .read_n, .write_n,
  .attribute_space_select, .addr, .data_oe, .char_visible, .led_enable,
  .custom_glyph_index, .display_control_word);

// ==== sim/lma_host.sv ====
// Purpose: host processor model on the parallel pins
// Assumes: each phase held well past the pin filter
// Notes:   released data lines show the inverse of the last byte
`timescale 1ns/1ps
module lma_host (
  // clock
  input  wire logic       ref_clk,
  // pins
  output logic            select_n,
  output logic            read_n,
  output logic            write_n,
  output logic            attribute_space_select,
  output logic [4:0]      addr,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  initial begin
    select_n = 1'h1;
    read_n = 1'h1;
    write_n = 1'h1;
    attribute_space_select = 1'h0;
    addr = 5'h00;
    data_in = 8'h00;
  end
  task automatic access(input logic rd, input logic fl, input logic [4:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    #1;
    attribute_space_select = fl;
    addr = a;
    data_in = d;
    select_n = 1'h0;
    read_n = !rd;
    write_n = rd;
    repeat (8) @(posedge ref_clk);
    q = data_oe ? data_out : 8'hxx;
    #1;
    select_n = 1'h1;
    read_n = 1'h1;
    write_n = 1'h1;
    data_in = ~d;
    repeat (7) @(posedge ref_clk);
  endtask
endmodule

// ==== sim/led_matrix_attribute_access_bench.sv ====
// Purpose: self-checking bench for lma_top
// Assumes: host model keeps the access spacing
// Notes:   flash half period measured in full, 14336 cycles
`timescale 1ns/1ps
module led_matrix_attribute_access_bench;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic select_n, read_n, write_n, attribute_space_select, data_oe, led_enable;
  logic [4:0] addr;
  logic [7:0] data_in, data_out, char_visible, display_control_word, q;
  logic [3:0] custom_glyph_index;
  int err_total = 0;
  int samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  lma_host u_host (.ref_clk, .select_n, .read_n, .write_n, .attribute_space_select,
    .addr, .data_in, .data_out, .data_oe);
  lma_top u_dut (.ref_clk, .resetn, .select_n, .read_n, .write_n, .attribute_space_select,
    .addr, .data_in, .data_out, .data_oe, .char_visible, .led_enable,
    .custom_glyph_index, .display_control_word);
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic fl, input logic [4:0] a, input logic [7:0] d);
    u_host.access(1'h0, fl, a, d, q);
  endtask
  task automatic rd(input logic fl, input logic [4:0] a);
    u_host.access(1'h1, fl, a, 8'h00, q);
  endtask
  // cycles until char_visible shows v; a lost phase ends the run
  task automatic wait_cv(input logic [7:0] v, output logic [15:0] n);
    n = 16'h0000;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 16'd20000) begin
        err_total++;
        summarize();
      end
    end while (char_visible !== v);
  endtask
  initial begin
    logic [15:0] n;
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'h1;
    repeat (3) @(posedge ref_clk);
    cmp("reset ctrl", 16'h0000, display_control_word);
    cmp("reset index", 16'h0000, custom_glyph_index);
    cmp("reset visible", 16'h00FF, char_visible);
    $display("test reset done");
    wr(1'h1, 5'h10, 8'h5A);
    cmp("ctrl", 16'h005A, display_control_word);
    rd(1'h1, 5'h17);
    cmp("ctrl read", 16'h005A, q);
    wr(1'h1, 5'h17, 8'hA0);
    cmp("ctrl whole", 16'h00A0, display_control_word);
    wr(1'h1, 5'h18, 8'h33);
    cmp("ctrl other space", 16'h00A0, display_control_word);
    $display("test control done");
    for (int c = 0; c < 8; c++) begin
      wr(1'h1, 5'h10, {4'h0, c[0], c[2:0]});
      n = 16'h0000;
      repeat (64) begin
        @(posedge ref_clk);
        #1;
        if (led_enable === 1'h1) n++;
      end
      // code 000 is lit in every slot, the others for (7 - code) of 8
      cmp("bright duty", 16'((c == 0) ? 64 : (7 - c) * 8), n);
    end
    $display("test brightness done");
    wr(1'h1, 5'h07, 8'hF3);
    cmp("glyph index", 16'h0003, custom_glyph_index);
    wr(1'h1, 5'h08, 8'hFF);
    wr(1'h1, 5'h0E, 8'h10);
    wr(1'h1, 5'h0F, 8'h1F);
    rd(1'h1, 5'h08);
    cmp("row top", 16'h001F, q);
    rd(1'h1, 5'h0E);
    cmp("row seven", 16'h0010, q);
    rd(1'h1, 5'h0F);
    cmp("row none", 16'h0000, q);
    $display("test glyph done");
    // the brightness loop leaves flash enabled; turn it off before the disabled check
    wr(1'h1, 5'h10, 8'h00);
    wr(1'h0, 5'h1A, 8'h01);
    wr(1'h0, 5'h05, 8'hFE);
    rd(1'h0, 5'h02);
    cmp("flash read", 16'h0001, q);
    cmp("flash disabled", 16'h00FF, char_visible);
    wr(1'h1, 5'h10, 8'h08);
    wait_cv(8'hFB, n);
    cmp("flash mask", 16'h00FB, char_visible);
    wait_cv(8'hFF, n);
    wait_cv(8'hFB, n);
    cmp("flash half", 16'd14336, n);
    wr(1'h1, 5'h10, 8'h00);
    cmp("flash off", 16'h00FF, char_visible);
    $display("test flash done");
    summarize();
  end
endmodule
